// file: rtl/pbs_pkg.sv
// Constants for the power-button and well sequencing block.
// Assumes a 100 MHz always-on resume-well clock.
package pbs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned DEBOUNCE_MS   = 16;
  localparam int unsigned OVERRIDE_S    = 4;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int unsigned OVERRIDE_CYC  = OVERRIDE_S * CLK_MHZ * 1000000;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  localparam logic [7:0] GEN_PM_CONFIG_SECOND_OFS = 8'ha2;
  localparam int unsigned PG_FAIL_BIT  = 0;
  localparam int unsigned AC_LOSS_BIT  = 1;
  localparam int unsigned BTN_STS_BIT  = 2;
  localparam int unsigned SMI_EN_BIT   = 3;
  localparam logic [7:0] GEN_PM_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Sleep states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PBS_S0 = 3'b000,
    PBS_S1 = 3'b001,
    PBS_S3 = 3'b011,
    PBS_S4 = 3'b100,
    PBS_S5 = 3'b101
  } pbs_state_t;

endpackage

// file: rtl/pbs_power_seq.sv
// Power-button debounce, sleep states, power-good failure and well
// isolation. Assumes all inputs synchronous to clk except the button.
//
// Notes on behaviour
// - Unexpected power-good drop sets failure flag bit0.
// - Flag set at S3 resume forces reboot.
// - Button debounced over 16 ms.
// - Loss of standby power recorded as AC failure.
// - States S1, S3, S4, S5 supported.
// - Valid press wakes from any sleep state.
// - Press in S0 raises SCI when enabled.
// - Without SCI, press raises SMI if enabled.
// - Press in S0 sets readable button status bit.
// - Four-second hold forces S5.
// - RTC well isolated while resume reset asserted.
// - Resume wells isolated while power-good low.
`timescale 1ns/1ps
module pbs_power_seq #(
  parameter logic [31:0] DEBOUNCE_CYC = 32'(pbs_pkg::DEBOUNCE_CYC),
  parameter logic [31:0] OVERRIDE_CYC = 32'(pbs_pkg::OVERRIDE_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Board pins
  input  wire logic        power_button_n,
  input  wire logic        power_good_in,
  input  wire logic        resume_well_reset_n,
  output logic             sleep_s3_out_n,
  // Sleep control from the power-management core
  input  wire logic        sleep_req,
  input  wire logic [2:0]  sleep_type,
  input  wire logic        sci_enable,
  output logic [2:0]       sleep_state,
  // Events
  output logic             button_sci,
  output logic             button_smi,
  output logic             resume_reboot,
  output logic             resume_continue,
  // Well isolation
  output logic             rtc_isolate,
  output logic             resume_isolate,
  // Configuration access
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               btn_s1;
    logic               btn_s2;
    logic               btn_last;
    logic               btn_stable;
    logic [31:0]        db_cnt;
    logic [31:0]        ovr_cnt;
    logic               ovr_done;
    logic               pg_q;
    logic               pg_fail;
    logic               ac_loss;
    logic               btn_sts;
    logic               smi_en;
    pbs_pkg::pbs_state_t st;
    logic               sleep_n;
    logic               sci;
    logic               smi;
    logic               reboot;
    logic               resume;
    logic               rtc_iso;
    logic               res_iso;
    logic [7:0]         rdata;
  } pbs_regs_t;

  pbs_regs_t r;
  pbs_regs_t next_r;

  logic press;
  logic pg_drop;
  logic reg_wr;
  logic ovr_fire;

  // Debounced fall seen from registered state only, so no loop via next_r
  assign press    = r.btn_stable & ~r.btn_s2 & ~r.btn_last &
                    (r.db_cnt >= DEBOUNCE_CYC - 32'h1);
  assign ovr_fire = ~r.btn_stable & ~r.ovr_done &
                    (r.ovr_cnt >= OVERRIDE_CYC - 32'h1);
  assign pg_drop = r.pg_q & ~power_good_in;
  assign reg_wr  = cfg_wr & (cfg_addr == pbs_pkg::GEN_PM_CONFIG_SECOND_OFS);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.sci    = 1'b0;
    next_r.smi    = 1'b0;
    next_r.reboot = 1'b0;
    next_r.resume = 1'b0;

    // Two-stage synchroniser, then debounce
    next_r.btn_s1   = power_button_n;
    next_r.btn_s2   = r.btn_s1;
    next_r.btn_last = r.btn_s2;
    if (r.btn_s2 != r.btn_last) begin
      next_r.db_cnt = 32'h0;
    end else if (r.btn_s2 != r.btn_stable) begin
      if (r.db_cnt >= DEBOUNCE_CYC - 32'h1) begin
        next_r.btn_stable = r.btn_s2;
        next_r.db_cnt     = 32'h0;
      end else begin
        next_r.db_cnt = r.db_cnt + 32'h1;
      end
    end else begin
      next_r.db_cnt = 32'h0;
    end

    // Hold timer for the emergency override
    if (r.btn_stable) begin
      next_r.ovr_cnt  = 32'h0;
      next_r.ovr_done = 1'b0;
    end else if (!r.ovr_done) begin
      next_r.ovr_cnt = r.ovr_cnt + 32'h1;
    end

    // Software register writes: bits 0..2 write-one-to-clear
    if (reg_wr) begin
      if (cfg_wdata[pbs_pkg::PG_FAIL_BIT]) next_r.pg_fail = 1'b0;
      if (cfg_wdata[pbs_pkg::AC_LOSS_BIT]) next_r.ac_loss = 1'b0;
      if (cfg_wdata[pbs_pkg::BTN_STS_BIT]) next_r.btn_sts = 1'b0;
      next_r.smi_en = cfg_wdata[pbs_pkg::SMI_EN_BIT];
    end

    // Hardware set wins over a same-cycle clear
    next_r.pg_q = power_good_in;
    if (pg_drop && (r.st == pbs_pkg::PBS_S0 || r.st == pbs_pkg::PBS_S1)) begin
      next_r.pg_fail = 1'b1;
    end
    if (!resume_well_reset_n) begin
      next_r.ac_loss = 1'b1;
    end

    // Sleep state machine
    unique case (r.st)
      pbs_pkg::PBS_S0: begin
        if (press) begin
          next_r.btn_sts = 1'b1;
          if (sci_enable) begin
            next_r.sci = 1'b1;
          end else if (r.smi_en) begin
            next_r.smi = 1'b1;
          end
        end else if (sleep_req) begin
          unique case (sleep_type)
            3'b001:  next_r.st = pbs_pkg::PBS_S1;
            3'b011:  next_r.st = pbs_pkg::PBS_S3;
            3'b100:  next_r.st = pbs_pkg::PBS_S4;
            3'b101:  next_r.st = pbs_pkg::PBS_S5;
            default: next_r.st = pbs_pkg::PBS_S0;
          endcase
        end
      end
      pbs_pkg::PBS_S1, pbs_pkg::PBS_S3,
      pbs_pkg::PBS_S4, pbs_pkg::PBS_S5: begin
        if (press) begin
          next_r.st = pbs_pkg::PBS_S0;
          if (r.st == pbs_pkg::PBS_S3) begin
            next_r.reboot = r.pg_fail;
            next_r.resume = ~r.pg_fail;
          end
        end
      end
      default: next_r.st = pbs_pkg::PBS_S5;
    endcase

    if (ovr_fire) begin
      next_r.st       = pbs_pkg::PBS_S5;
      next_r.ovr_done = 1'b1;
      next_r.sci      = 1'b0;
      next_r.smi      = 1'b0;
    end

    // Core wells off in S3 and deeper
    next_r.sleep_n = ~(next_r.st == pbs_pkg::PBS_S3 ||
                       next_r.st == pbs_pkg::PBS_S4 ||
                       next_r.st == pbs_pkg::PBS_S5);

    next_r.rtc_iso = ~resume_well_reset_n;
    next_r.res_iso = ~power_good_in;

    if (cfg_rd && cfg_addr == pbs_pkg::GEN_PM_CONFIG_SECOND_OFS) begin
      next_r.rdata = {4'h0, r.smi_en, r.btn_sts, r.ac_loss, r.pg_fail};
    end else begin
      next_r.rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r            <= '0;
      r.btn_s1     <= 1'b1;
      r.btn_s2     <= 1'b1;
      r.btn_last   <= 1'b1;
      r.btn_stable <= 1'b1;
      r.st         <= pbs_pkg::PBS_S5;
      r.sleep_n    <= 1'b0;
      r.rtc_iso    <= 1'b1;
      r.res_iso    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign sleep_s3_out_n  = r.sleep_n;
  assign sleep_state     = r.st;
  assign button_sci      = r.sci;
  assign button_smi      = r.smi;
  assign resume_reboot   = r.reboot;
  assign resume_continue = r.resume;
  assign rtc_isolate     = r.rtc_iso;
  assign resume_isolate  = r.res_iso;
  assign cfg_rdata       = r.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pg_fail_set: assert property (@(posedge clk) disable iff (rst)
    (r.pg_q && !power_good_in && r.st == pbs_pkg::PBS_S0)
      |=> r.pg_fail)
    else $error("power-good drop in S0 did not set the flag");

  a_s3_reboot: assert property (@(posedge clk) disable iff (rst)
    (r.st == pbs_pkg::PBS_S3 && press && r.pg_fail)
      |=> resume_reboot && !resume_continue)
    else $error("S3 resume with failure flag did not reboot");

  a_debounce_len: assert property (@(posedge clk) disable iff (rst)
    (r.btn_stable != $past(r.btn_stable))
      |-> ($past(r.db_cnt) == DEBOUNCE_CYC - 32'h1))
    else $error("debounced button changed before full interval");

  a_ac_loss: assert property (@(posedge clk) disable iff (rst)
    !resume_well_reset_n |=> r.ac_loss)
    else $error("standby loss not recorded");

  a_wake_press: assert property (@(posedge clk) disable iff (rst)
    (r.st != pbs_pkg::PBS_S0 && press && r.btn_stable)
      |=> sleep_state == pbs_pkg::PBS_S0 || r.ovr_done)
    else $error("press did not wake from sleep");

  a_sci_path: assert property (@(posedge clk) disable iff (rst)
    button_sci |-> $past(sci_enable) && !button_smi && r.btn_sts)
    else $error("SCI raised without enable");

  a_smi_path: assert property (@(posedge clk) disable iff (rst)
    button_smi |-> !$past(sci_enable) && $past(r.smi_en))
    else $error("SMI raised with SCI enabled or SMI disabled");

  a_override: assert property (@(posedge clk) disable iff (rst)
    (!r.btn_stable && !r.ovr_done && r.ovr_cnt == OVERRIDE_CYC - 32'h1)
      |=> sleep_state == pbs_pkg::PBS_S5 && !sleep_s3_out_n)
    else $error("four-second hold did not force soft-off");

  a_rtc_iso: assert property (@(posedge clk) disable iff (rst)
    !resume_well_reset_n |=> rtc_isolate)
    else $error("RTC well not isolated during resume reset");

  a_res_iso: assert property (@(posedge clk) disable iff (rst)
    !power_good_in [*2] |-> resume_isolate)
    else $error("resume wells not isolated while power-good low");

endmodule // pbs_power_seq

// file: tb/pbs_board_model.sv
// Board glue and supply model facing the sequencing block.
// Assumes clk is shared; the bench drives standby and pg_fault.
`timescale 1ns/1ps
module pbs_board_model #(
  parameter int RST_DLY = 4,
  parameter int PG_DLY  = 4
) (
  // Clock
  input  wire logic clk,
  // Bench controls
  input  wire logic standby,
  input  wire logic pg_fault,
  // Block pins
  input  wire logic sleep_s3_out_n,
  output logic      supply_on_request,
  output logic      power_good_in,
  output logic      resume_well_reset_n
);
  int   rcnt  = 0;
  int   pcnt  = 0;
  logic core_on;
  logic pg_q  = 1'b0;
  logic rsm_q = 1'b0;

  assign supply_on_request   = ~sleep_s3_out_n;
  assign core_on             = ~supply_on_request;
  assign power_good_in       = pg_q;
  assign resume_well_reset_n = rsm_q;

  // Registered outputs stay glitch free
  always @(posedge clk) begin
    rcnt  <= standby ? rcnt + 1 : 0;
    rsm_q <= standby && rcnt >= RST_DLY;
    pcnt  <= core_on ? pcnt + 1 : 0;
    // Old reset value: power-good falls one edge after reset
    pg_q  <= core_on && !pg_fault && rsm_q && pcnt >= PG_DLY;
  end
endmodule // pbs_board_model

// file: tb/power_button_and_well_sequencing_tb.sv
// Self-checking bench for the power sequencing block.
// Assumes the board model supplies power-good and resume reset.
`timescale 1ns/1ps
module power_button_and_well_sequencing_tb;
  localparam int DEB = 8;
  localparam int OVR = 64;
  localparam logic [7:0] A2 = pbs_pkg::GEN_PM_CONFIG_SECOND_OFS;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       btn_n = 1'b1;
  logic       standby = 1'b1;
  logic       pg_fault = 1'b0;
  logic       sleep_req = 1'b0;
  logic [2:0] sleep_type = 3'h0;
  logic       sci_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic       cfg_wr = 1'b0;
  logic       cfg_rd = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic [2:0] st;
  logic       s3_n, sci, smi, boot, cont, rtc_iso, res_iso, pg, rsm_n;
  int         n_fail = 0, cmp_count = 0, cycles = 0;
  int         n_sci = 0, n_smi = 0, n_boot = 0, n_cont = 0;
  pbs_pkg::pbs_state_t tl [4] = '{pbs_pkg::PBS_S1, pbs_pkg::PBS_S3,
                                  pbs_pkg::PBS_S4, pbs_pkg::PBS_S5};

  initial begin
    forever #5 clk = ~clk;
  end

  pbs_power_seq #(.DEBOUNCE_CYC(32'(DEB)), .OVERRIDE_CYC(32'(OVR)))
  i_pbs_power_seq (.clk(clk), .rst(rst), .power_button_n(btn_n),
    .power_good_in(pg), .resume_well_reset_n(rsm_n),
    .sleep_s3_out_n(s3_n), .sleep_req(sleep_req),
    .sleep_type(sleep_type), .sci_enable(sci_en), .sleep_state(st),
    .button_sci(sci), .button_smi(smi), .resume_reboot(boot),
    .resume_continue(cont), .rtc_isolate(rtc_iso),
    .resume_isolate(res_iso), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

  pbs_board_model i_pbs_board_model (.clk(clk), .standby(standby),
    .pg_fault(pg_fault), .sleep_s3_out_n(s3_n),
    .supply_on_request(), .power_good_in(pg),
    .resume_well_reset_n(rsm_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask

  // Data stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, m, e);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cyc(1);
    cfg_rd = 1'b0;
    chk("cfg_rdata", e, cfg_rdata & m);
    cyc(1);
  endtask

  task automatic press(input int hold);
    btn_n = 1'b0;
    cyc(hold);
    btn_n = 1'b1;
    cyc(DEB + 8);
  endtask

  task automatic sleep_go(input logic [2:0] t);
    sleep_type = t;
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    cyc(8);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_sci <= n_sci + 32'(sci === 1'b1);
    n_smi <= n_smi + 32'(smi === 1'b1);
    n_boot <= n_boot + 32'(boot === 1'b1);
    n_cont <= n_cont + 32'(cont === 1'b1);
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    rst = 1'b0;
    chk("state", 8'(pbs_pkg::PBS_S5), 8'(st));
    cyc(8);
    chk("rtc_isolate", 8'h00, 8'(rtc_iso));
    chk("resume_isolate", 8'h01, 8'(res_iso));
    rd(A2, 8'hff, 8'h02);
    wr(A2, 8'h02);
    wr(8'ha3, 8'hff);
    rd(A2, 8'hff, 8'h00);
    rd(8'ha3, 8'hff, 8'h00);
    $display("test reset done");
    btn_n = 1'b0;
    cyc(2);
    btn_n = 1'b1;
    cyc(DEB + 8);
    chk("glitch state", 8'(pbs_pkg::PBS_S5), 8'(st));
    btn_n = 1'b0;
    cyc(DEB + 2);
    chk("early state", 8'(pbs_pkg::PBS_S5), 8'(st));
    cyc(6);
    btn_n = 1'b1;
    chk("woken state", 8'(pbs_pkg::PBS_S0), 8'(st));
    cyc(DEB + 8);
    chk("resume_isolate", 8'h00, 8'(res_iso));
    $display("test wake done");
    sci_en = 1'b1;
    wr(A2, 8'h04);
    press(DEB + 8);
    chk("sci count", 8'h01, 8'(n_sci));
    rd(A2, 8'h04, 8'h04);
    sci_en = 1'b0;
    press(DEB + 8);
    chk("smi off", 8'h00, 8'(n_smi));
    wr(A2, 8'h0c);
    press(DEB + 8);
    chk("smi count", 8'h01, 8'(n_smi));
    rd(A2, 8'h0c, 8'h0c);
    wr(A2, 8'h04);
    $display("test events done");
    sleep_go(3'h2);
    chk("bad sleep type", 8'(pbs_pkg::PBS_S0), 8'(st));
    foreach (tl[i]) begin
      sleep_go(tl[i]);
      chk("sleep state", 8'(tl[i]), 8'(st));
      chk("s3 out", 8'(tl[i] == pbs_pkg::PBS_S1), 8'(s3_n));
      press(DEB + 8);
      chk("wake state", 8'(pbs_pkg::PBS_S0), 8'(st));
    end
    chk("continue", 8'h01, 8'(n_cont));
    rd(A2, 8'h01, 8'h00);
    $display("test sleep done");
    pg_fault = 1'b1;
    cyc(3);
    chk("resume_isolate", 8'h01, 8'(res_iso));
    rd(A2, 8'h01, 8'h01);
    pg_fault = 1'b0;
    cyc(8);
    sleep_go(pbs_pkg::PBS_S3);
    press(DEB + 8);
    chk("reboot", 8'h01, 8'(n_boot));
    chk("continue", 8'h01, 8'(n_cont));
    wr(A2, 8'h07);
    $display("test failure done");
    press(DEB + OVR + 10);
    chk("override", 8'(pbs_pkg::PBS_S5), 8'(st));
    chk("s3 out", 8'h00, 8'(s3_n));
    standby = 1'b0;
    cyc(3);
    chk("rtc_isolate", 8'h01, 8'(rtc_iso));
    rd(A2, 8'h03, 8'h02);
    $display("test override done");
    results();
  end
endmodule // power_button_and_well_sequencing_tb
